// ---- src/adc_seq_pkg.sv ----
// Package: register map, field layout and timing for the converter sequencer
package adc_seq_pkg;

  // Register byte addresses
  localparam logic [7:0] OFF_CONTROL_PRIMARY = 8'h00;
  localparam logic [7:0] OFF_CONTROL_SECOND  = 8'h04;
  localparam logic [7:0] OFF_SCAN_LIST       = 8'h08;
  localparam logic [7:0] OFF_STATUS          = 8'h0C;
  localparam logic [7:0] OFF_RESULT_BASE     = 8'h40;

  // Primary control field positions
  localparam int POS_POWER_ON  = 15;
  localparam int POS_IDLE_STOP = 13;
  localparam int POS_FORMAT    = 8;
  localparam int POS_TRIGGER   = 5;
  localparam int POS_SIMUL     = 3;
  localparam int POS_AUTO      = 2;
  localparam int POS_SAMPLE    = 1;
  localparam int POS_DONE      = 0;

  // Secondary control field positions
  localparam int POS_SCAN_EN   = 10;
  localparam int POS_CHANNELS  = 8;
  localparam int POS_SEQ_IRQ   = 2;

  // Status field positions
  localparam int POS_IRQ_FLAG  = 0;
  localparam int POS_BUF_PTR   = 4;

  // Reset values
  localparam logic [15:0] RST_CONTROL = 16'h0000;
  localparam logic [15:0] RST_SCAN    = 16'h0000;

  // Trigger codes
  localparam logic [2:0] TRIG_SOFTWARE = 3'h0;
  localparam logic [2:0] TRIG_EXT_IRQ0 = 3'h1;
  localparam logic [2:0] TRIG_TIMER3   = 3'h2;
  localparam logic [2:0] TRIG_PWM_END  = 3'h3;
  localparam logic [2:0] TRIG_CHARGE   = 3'h6;

  // Result format codes
  localparam logic [1:0] FMT_UINT  = 2'h0;
  localparam logic [1:0] FMT_SINT  = 2'h1;
  localparam logic [1:0] FMT_UFRAC = 2'h2;
  localparam logic [1:0] FMT_SFRAC = 2'h3;

  // Conversion timing: 12 conversion clocks, one per mclk
  localparam int CONV_CYCLES = 12;

  typedef enum logic [1:0] {
    ST_OFF    = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONV   = 2'b11,
    ST_HOLD   = 2'b10
  } phase_t;

  // APB request bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // Hardware trigger inputs
  typedef struct packed {
    logic ext_irq_zero;
    logic timer3_match;
    logic pwm_interval_end;
    logic charge_time_unit;
  } trig_t;

endpackage

// ---- src/adc_sequence_control.sv ----
// Converter sequencing and control with APB register access
// Functional notes
// RQ1: Converter runs only while power-on bit set.
// RQ2: Idle-stop bit halts converter in Idle.
// RQ3: Format field picks one of four alignments.
// RQ4: Trigger field selects sample end source.
// RQ5: Simultaneous bit samples channel group together.
// RQ6: Auto-start resamples after conversion, sets sample.
// RQ7: Software sets sample; clears it to convert.
// RQ8: Hardware sets complete flag on conversion end.
// RQ9: Software clears complete flag; conversion unaffected.
// RQ10: Hardware clears complete flag only at conversion start.
// RQ11: Sequence count decides interrupt flag setting.
// RQ12: Scan list restarts at interrupt point.
// RQ13: Results go in order to 16 entries.
// RQ14: Four sample-and-hold channels, 14 inputs.
// RQ15: Converter may run in Sleep or Idle.
// RQ16: Software configures in documented order.
// RQ17: Software clears complete flag before sampling.
// RQ18: Channel count selects two or four channels. Code also selects one channel when the field is zero.
// RQ19: Interrupt after every N+1 sequences.
// RQ20: Buffer pointer rewinds when interrupt flag set.
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module adc_sequence_control
  import adc_seq_pkg::*;
#(
  parameter int NUM_INPUTS = 14,
  parameter int BUF_DEPTH  = 16
) (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst,
  // APB slave
  input  wire adc_seq_pkg::apb_req_t  apb_req,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Power state and triggers
  input  wire logic                   cpu_idle,
  input  wire adc_seq_pkg::trig_t     triggers,
  // Analog front end
  input  wire logic [9:0]             conv_value,
  output logic [3:0]                  hold_enable,
  output logic [3:0]                  input_select,
  output logic                        converter_irq_flag
);
  import adc_seq_pkg::*;

  // Refuse sizes the buffer and scan logic cannot serve
  initial begin
    if (BUF_DEPTH != 16 || NUM_INPUTS < 1 || NUM_INPUTS > 16) begin
      $error("adc_sequence_control: unsupported parameter values");
    end
  end

  // Whole module state
  typedef struct packed {
    logic [15:0]               ctrl1;
    logic [15:0]               ctrl2;
    logic [15:0]               scan;
    phase_t                    phase;
    logic [3:0]                conv_cnt;
    logic [1:0]                chan;
    logic [3:0]                scan_pos;
    logic [3:0]                seq_cnt;
    logic [3:0]                wptr;
    logic                      irq;
    logic                      ext_prev;
    logic [BUF_DEPTH-1:0][15:0] buffer;
    logic [31:0]               rdata;
    logic [3:0]                hold;
    logic [3:0]                sel;
  } state_t;

  state_t cur;
  state_t next_s;

  // Format a 10-bit raw result into the chosen alignment
  function automatic logic [15:0] format_result(input logic [1:0] fmt, input logic [9:0] raw);
    logic [9:0] sgn;
    sgn = raw ^ 10'h200;
    unique case (fmt)
      FMT_UINT:  format_result = {6'h00, raw};
      FMT_SINT:  format_result = {{6{sgn[9]}}, sgn};
      FMT_UFRAC: format_result = {raw, 6'h00};
      FMT_SFRAC: format_result = {sgn, 6'h00};
    endcase
  endfunction

  // Next scan input after pos with its select bit set, wrapping
  function automatic logic [3:0] next_scan(input logic [15:0] list, input logic [3:0] pos);
    logic [3:0] p;
    logic       hit;
    p   = pos;
    hit = 1'b0;
    for (int i = 1; i <= 16; i++) begin
      if (!hit && list[4'(pos + 4'(i))]) begin
        p   = 4'(pos + 4'(i));
        hit = 1'b1;
      end
    end
    next_scan = p;
  endfunction

  // First selected scan input
  function automatic logic [3:0] first_scan(input logic [15:0] list);
    first_scan = next_scan(list, 4'hF);
  endfunction

  logic       access;
  logic       run;
  logic       hw_trig;
  logic [1:0] last_chan;

  // APB access phase: zero wait states
  assign access  = apb_req.psel && apb_req.penable;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign prdata  = cur.rdata;

  always_comb begin
    next_s   = cur;
    // RQ1 powered; RQ2 idle stop; RQ15 otherwise runs in idle or sleep
    run = cur.ctrl1[POS_POWER_ON] && !(cur.ctrl1[POS_IDLE_STOP] && cpu_idle);
    // RQ18 channel group size
    last_chan = cur.ctrl2[POS_CHANNELS+1] ? 2'h3 : (cur.ctrl2[POS_CHANNELS] ? 2'h1 : 2'h0);
    // RQ4 trigger source decode
    unique case (cur.ctrl1[POS_TRIGGER +: 3])
      TRIG_EXT_IRQ0: hw_trig = triggers.ext_irq_zero && !cur.ext_prev;
      TRIG_TIMER3:   hw_trig = triggers.timer3_match;
      TRIG_PWM_END:  hw_trig = triggers.pwm_interval_end;
      TRIG_CHARGE:   hw_trig = triggers.charge_time_unit;
      default:       hw_trig = 1'b0;
    endcase
    next_s.ext_prev = triggers.ext_irq_zero;

    // Register writes; read data captured in setup so it is stable in access
    if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
      next_s.rdata = 32'h0000_0000;
      if (apb_req.paddr == OFF_CONTROL_PRIMARY) begin
        next_s.rdata = {16'h0000, cur.ctrl1};
      end else if (apb_req.paddr == OFF_CONTROL_SECOND) begin
        next_s.rdata = {16'h0000, cur.ctrl2};
      end else if (apb_req.paddr == OFF_SCAN_LIST) begin
        next_s.rdata = {16'h0000, cur.scan};
      end else if (apb_req.paddr == OFF_STATUS) begin
        next_s.rdata = {24'h000000, cur.wptr, 3'h0, cur.irq};
      end else if (apb_req.paddr[7:6] == OFF_RESULT_BASE[7:6] && apb_req.paddr[1:0] == 2'h0) begin
        next_s.rdata = {16'h0000, cur.buffer[apb_req.paddr[5:2]]};
      end
    end
    if (access && apb_req.pwrite) begin
      if (apb_req.paddr == OFF_CONTROL_PRIMARY) begin
        next_s.ctrl1 = apb_req.pwdata[15:0] & 16'hA3EF;
        // RQ9 software may only clear the done bit, never set it
        next_s.ctrl1[POS_DONE] = cur.ctrl1[POS_DONE] & apb_req.pwdata[POS_DONE];
        // RQ7 sample bit follows software write
        next_s.ctrl1[POS_SAMPLE] = apb_req.pwdata[POS_SAMPLE];
      end else if (apb_req.paddr == OFF_CONTROL_SECOND) begin
        next_s.ctrl2 = apb_req.pwdata[15:0] & 16'h073C;
      end else if (apb_req.paddr == OFF_SCAN_LIST) begin
        next_s.scan = apb_req.pwdata[15:0] & 16'((32'h1 << NUM_INPUTS) - 1);
      end else if (apb_req.paddr == OFF_STATUS && !apb_req.pwdata[POS_IRQ_FLAG]) begin
        next_s.irq = 1'b0;
      end
    end

    // Sequencer
    unique case (cur.phase)
      ST_OFF: begin
        next_s.hold = 4'h0;
        if (run) begin
          next_s.phase    = ST_SAMPLE;
          next_s.scan_pos = first_scan(cur.scan);
        end
      end
      ST_SAMPLE: begin
        // RQ5 simultaneous or single-channel hold; RQ14 four holds
        next_s.hold = cur.ctrl1[POS_SIMUL] ? 4'((5'h2 << last_chan) - 5'h1) : 4'h1;
        next_s.sel  = cur.ctrl2[POS_SCAN_EN] ? cur.scan_pos : 4'h0;
        if (!run) begin
          // RQ1 RQ2 holds drop at once, not one cycle late
          next_s.hold  = 4'h0;
          next_s.phase = ST_OFF;
        end else if (next_s.ctrl1[POS_SAMPLE] &&
                     (hw_trig && cur.ctrl1[POS_TRIGGER +: 3] != TRIG_SOFTWARE)) begin
          next_s.ctrl1[POS_SAMPLE] = 1'b0;
          next_s.phase = ST_CONV;
        end else if (cur.ctrl1[POS_SAMPLE] && !next_s.ctrl1[POS_SAMPLE] &&
                     cur.ctrl1[POS_TRIGGER +: 3] == TRIG_SOFTWARE) begin
          // RQ7 software clear of sample starts conversion
          next_s.phase = ST_CONV;
        end
        if (next_s.phase == ST_CONV) begin
          // RQ10 hardware clears done only at conversion start
          next_s.ctrl1[POS_DONE] = 1'b0;
          next_s.hold     = 4'h0;
          next_s.conv_cnt = 4'h0;
          next_s.chan     = 2'h0;
        end
      end
      ST_CONV: begin
        if (!run) begin
          next_s.phase = ST_OFF;
        end else if (cur.conv_cnt == 4'(CONV_CYCLES - 1)) begin
          // RQ13 sequential buffer write; RQ3 alignment
          next_s.buffer[cur.wptr] = format_result(cur.ctrl1[POS_FORMAT +: 2], conv_value);
          next_s.wptr     = 4'(cur.wptr + 4'h1);
          next_s.conv_cnt = 4'h0;
          if (cur.chan == last_chan) begin
            next_s.phase = ST_HOLD;
          end else begin
            next_s.chan = 2'(cur.chan + 2'h1);
          end
        end else begin
          next_s.conv_cnt = 4'(cur.conv_cnt + 4'h1);
        end
      end
      ST_HOLD: begin
        // RQ8 done set at conversion end
        next_s.ctrl1[POS_DONE] = 1'b1;
        next_s.scan_pos = next_scan(cur.scan, cur.scan_pos);
        // RQ11 RQ19 interrupt after N+1 sequences
        if (cur.seq_cnt == cur.ctrl2[POS_SEQ_IRQ +: 4]) begin
          next_s.seq_cnt = 4'h0;
          next_s.irq     = 1'b1;
          // RQ20 pointer rewinds
          next_s.wptr    = 4'h0;
          // RQ12 scan restarts from first entry
          next_s.scan_pos = first_scan(cur.scan);
        end else begin
          next_s.seq_cnt = 4'(cur.seq_cnt + 4'h1);
        end
        // RQ6 auto-start sets sample again
        if (cur.ctrl1[POS_AUTO]) begin
          next_s.ctrl1[POS_SAMPLE] = 1'b1;
        end
        next_s.phase = run ? ST_SAMPLE : ST_OFF;
      end
    endcase
  end

  // Single state register; set beats clear on flags via ordering above
  always_ff @(posedge mclk) begin
    if (rst) begin
      cur       <= '0;
      cur.ctrl1 <= RST_CONTROL;
      cur.ctrl2 <= RST_CONTROL;
      cur.scan  <= RST_SCAN;
      cur.phase <= ST_OFF;
    end else begin
      cur <= next_s;
    end
  end

  assign hold_enable        = cur.hold;
  assign input_select       = cur.sel;
  assign converter_irq_flag = cur.irq;

endmodule

// ---- tb/adc_seq_props.sv ----
// Checker: port-level properties of the converter sequencer
`timescale 1ns/1ps
module adc_seq_props
  import adc_seq_pkg::*;
(
  // Clock and reset
  input wire logic                  mclk,
  input wire logic                  rst,
  // Bus and outputs watched
  input wire adc_seq_pkg::apb_req_t apb_req,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic [3:0]            hold_enable,
  input wire logic                  converter_irq_flag
);
  import adc_seq_pkg::*;
  logic [15:0] ctl_sh;
  logic [15:0] scan_sh;
  logic        wr;
  logic        rd_set;
  assign wr     = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign rd_set = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
  // Shadow of software-only bits; hardware-owned bits are not trusted here
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctl_sh  <= 16'h0000;
      scan_sh <= 16'h0000;
    end else if (wr && apb_req.paddr == OFF_CONTROL_PRIMARY) begin
      ctl_sh <= apb_req.pwdata[15:0];
    end else if (wr && apb_req.paddr == OFF_SCAN_LIST) begin
      scan_sh <= apb_req.pwdata[15:0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_access; apb_req.psel && apb_req.penable |-> pready && !pslverr; endproperty
  a_access: assert property (p_access) else $error("bus answer wrong");
  property p_reset; $fell(rst) |-> hold_enable == 4'h0 && !converter_irq_flag && prdata == 32'h0; endproperty
  a_reset: assert property (p_reset) else $error("outputs not clear after reset");
  property p_off; !ctl_sh[POS_POWER_ON] && $past(!ctl_sh[POS_POWER_ON]) |-> hold_enable == 4'h0; endproperty
  a_off: assert property (p_off) else $error("sampling while powered off");
  property p_seq; !ctl_sh[POS_SIMUL] && $past(!ctl_sh[POS_SIMUL]) |-> $onehot0(hold_enable); endproperty
  a_seq: assert property (p_seq) else $error("several holds outside simultaneous mode");
  property p_sticky; converter_irq_flag && !(wr && apb_req.paddr == OFF_STATUS) |=> converter_irq_flag; endproperty
  a_sticky: assert property (p_sticky) else $error("irq flag dropped by itself");
  property p_irq_on; $rose(converter_irq_flag) |-> ctl_sh[POS_POWER_ON]; endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq flag set while off");
  property p_clr;
    wr && apb_req.paddr == OFF_STATUS && !apb_req.pwdata[0] && !ctl_sh[POS_POWER_ON] |=> !converter_irq_flag;
  endproperty
  a_clr: assert property (p_clr) else $error("irq flag not cleared");
  property p_upper; apb_req.psel && apb_req.penable && !apb_req.pwrite |-> prdata[31:16] == 16'h0000; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_unmap; rd_set && apb_req.paddr == 8'h10 |=> prdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_scan; rd_set && apb_req.paddr == OFF_SCAN_LIST |=> prdata[15:0] == scan_sh; endproperty
  a_scan: assert property (p_scan) else $error("scan list readback wrong");
  // Main scenarios reached
  c_irq: cover property ($rose(converter_irq_flag));
  c_hold: cover property (hold_enable != 4'h0);
  c_clr: cover property (wr && apb_req.paddr == OFF_STATUS);
endmodule
bind adc_sequence_control adc_seq_props u_props (.mclk, .rst, .apb_req, .prdata, .pready, .pslverr,
  .hold_enable, .converter_irq_flag);

// ---- tb/adc_far_model.sv ----
// Far-side model: on-chip trigger sources and analog result source
`timescale 1ns/1ps
module adc_far_model
  import adc_seq_pkg::*;
(
  // Bench control
  input  wire logic         fire,
  // Toward the sequencer
  output adc_seq_pkg::trig_t triggers,
  output logic [9:0]        conv_value
);
  import adc_seq_pkg::*;
  // every source pulses; only the selected one may act
  assign triggers   = '{default: fire};
  // Fixed level keeps expected buffer words simple
  assign conv_value = 10'h2A5;
endmodule

// ---- tb/tb.sv ----
// Testbench: register table, conversions, irq count and buffer rewind
`timescale 1ns/1ps
module tb;
  import adc_seq_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cpu_idle = 1'b0;
  logic fire = 1'b0;
  apb_req_t req = '0;
  logic [31:0] prdata;
  logic [31:0] r;
  logic pready;
  logic [3:0] hold_o;
  logic [3:0] sel_o;
  logic irq_o;
  trig_t trg;
  logic [9:0] cv;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [55:0] rows [8] = '{{8'h00, 32'h0160, 16'h0160}, {8'h00, 32'h02C0, 16'h02C0},
    {8'h00, 32'h0320, 16'h0320}, {8'h00, 32'h0040, 16'h0040}, {8'h04, 32'h0704, 16'h0704},
    {8'h08, 32'h0005, 16'h0005}, {8'h10, 32'h1234, 16'h0000}, {8'h00, 32'h0000, 16'h0000}};
  always #50 mclk = ~mclk;
  adc_far_model far (.fire(fire), .triggers(trg), .conv_value(cv));
  adc_sequence_control dut (.mclk(mclk), .rst(rst), .apb_req(req), .prdata(prdata), .pready(pready),
    .pslverr(), .cpu_idle(cpu_idle), .triggers(trg), .conv_value(cv), .hold_enable(hold_o), .input_select(sel_o),
    .converter_irq_flag(irq_o));
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; request held until pready is seen high
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge mclk);
    req.penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    req <= '0;
  endtask
  task poll_done;
    int k;
    k = 0;
    do begin
      xfer(1'b0, OFF_CONTROL_PRIMARY, 32'h0);
      k++;
    end while (r[0] !== 1'b1 && k < 60);
  endtask
  // Hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 16; i += 4) begin
      xfer(1'b0, 8'(i), 32'h0);
      chk(r, 32'h0);
    end
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, rows[i][55:48], rows[i][47:16]);
      xfer(1'b0, rows[i][55:48], 32'h0);
      chk(r, {16'h0, rows[i][15:0]});
    end
    // configure before power-on, then software sample and convert
    xfer(1'b1, OFF_CONTROL_SECOND, 32'h0004);
    xfer(1'b1, OFF_CONTROL_PRIMARY, 32'h8000);
    xfer(1'b1, OFF_CONTROL_PRIMARY, 32'h8002);
    xfer(1'b1, OFF_CONTROL_PRIMARY, 32'h8000);
    poll_done();
    chk(r, 32'h8001);
    xfer(1'b0, OFF_STATUS, 32'h0);
    chk(r, 32'h0010);
    xfer(1'b0, OFF_RESULT_BASE, 32'h0);
    chk(r, 32'h02A5);
    // clear done before the next sample phase
    xfer(1'b1, OFF_CONTROL_PRIMARY, 32'h8000);
    xfer(1'b0, OFF_CONTROL_PRIMARY, 32'h0);
    chk(r, 32'h8000);
    // Timer trigger with auto-start
    xfer(1'b1, OFF_CONTROL_PRIMARY, 32'h8046);
    @(posedge mclk);
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
    poll_done();
    chk(r, 32'h8047);
    xfer(1'b0, OFF_STATUS, 32'h0);
    chk(r, 32'h0001);
    chk({31'h0, irq_o}, 32'h1);
    xfer(1'b0, OFF_RESULT_BASE + 8'h04, 32'h0);
    chk(r, 32'h02A5);
    // Auto-start left the single hold sampling input zero
    chk({28'h0, hold_o}, 32'h1);
    chk({28'h0, sel_o}, 32'h0);
    // Idle with idle-stop set halts sampling
    xfer(1'b1, OFF_CONTROL_PRIMARY, 32'hA046);
    @(posedge mclk);
    cpu_idle <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({28'h0, hold_o}, 32'h0);
    cpu_idle <= 1'b0;
    xfer(1'b1, OFF_CONTROL_PRIMARY, 32'h0);
    xfer(1'b1, OFF_STATUS, 32'h0);
    xfer(1'b0, OFF_STATUS, 32'h0);
    chk(r, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    chk({28'h0, hold_o}, 32'h0);
    final_report();
  end
endmodule
